// >>> mdcf_framer.sv
// Multi-drop command framer: parses host blocks, answers ACK/NAK, hands
// the command to the pump_interface_unit and frames its response.
// Assumes a half-duplex byte link: rx bytes arrive as one-cycle strobes
// synchronous to clk_sys, tx bytes leave on a valid/ready handshake.
// Operation
// - Control message: space, function code, parameters
// - Query message: question mark, function code, parameters
// - Parameters are ASCII hex digits, 16-bit signed
// - Type and function only in first block
// - Success reply: address, STX, 001, '#', ETX, checksum
// - Failure reply: '!' plus three-character error code
// - Execute only after ACK of final block
// - Single block: '@', address, STX, 001, message
// - Two blocks split after 253rd parameter
// - Long query reply: block one, wait ACK, two
// - Checksum seeded FF, XOR of STX through end
// - Address 1 to 127 as two hex digits
// - ETB ends non-final blocks, ETX the final one
`timescale 1ns/1ps
module mdcf_framer #(
  parameter int DEPTH = mdcf_pkg::PARAM_DEPTH
) (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic [6:0]          myAddr,
  input  wire logic                rxValid,
  input  wire logic [7:0]          rxData,
  output logic                     txValid,
  input  wire logic                txReady,
  output logic      [7:0]          txData,
  output logic                     cmdValid,
  output mdcf_pkg::mdcf_cmd_t      cmd,
  input  wire logic                respValid,
  input  wire mdcf_pkg::mdcf_resp_t resp,
  output logic      [8:0]          replyIdx,
  input  wire logic [7:0]          replyChar,
  input  wire logic [8:0]          paramRdIdx,
  output logic      [7:0]          paramRdData
);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDRH, S_ADDRL, S_STX, S_BLK0, S_BLK1, S_BLK2, S_BODY,
    S_LRC, S_REPLY, S_EXEC, S_RSP, S_HOSTACK
  } mdcf_state_t;

  mdcf_state_t          stateQ, stateD;
  logic [8:0]           seqQ, seqD, idxQ, idxD, paramCntQ, paramCntD;
  logic [8:0]           payLenQ, payLenD, chIdx, pIdx, termIdx;
  logic [1:0]           blkExpQ, blkExpD, blkRxQ, blkRxD, blkTxQ, blkTxD;
  logic                 bodyErrQ, bodyErrD, isQueryQ, isQueryD;
  logic                 endEtxQ, endEtxD, addrOkQ, addrOkD;
  logic                 replyAckQ, replyAckD, issuedQ, issuedD;
  logic                 txValidQ, txValidD;
  logic [7:0]           txDataQ, txDataD, fnCodeQ, fnCodeD, charAt;
  mdcf_pkg::mdcf_resp_t respQ, respD;
  logic                 lrcClr, lrcEn, ramWe, multi;
  logic [7:0]           lrcIn, lrcQ, addrHi, addrLo;

  // Own address as it appears on the wire
  assign addrHi = mdcf_pkg::hexToAscii({1'b0, myAddr[6:4]});
  assign addrLo = mdcf_pkg::hexToAscii(myAddr[3:0]);

  mdcf_lrc u_lrc (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clr     (lrcClr),
    .en      (lrcEn),
    .din     (lrcIn),
    .lrc_q   (lrcQ)
  );

  mdcf_param_ram #(.DEPTH(DEPTH)) u_ram (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .wrEn     (ramWe),
    .wrIdx    (paramCntQ),
    .wrData   (rxData),
    .rdIdx    (paramRdIdx),
    .rdData_q (paramRdData)
  );

  // Payload length of a response block
  function automatic logic [8:0] payLen(input mdcf_pkg::mdcf_resp_t r,
                                        input logic q, input logic blk2);
    if (!r.ok) payLen = mdcf_pkg::FAIL_LEN;
    else if (!q) payLen = mdcf_pkg::OK_LEN;
    else if (blk2) payLen = r.replyLen - mdcf_pkg::BLK1_PARAMS;
    else if (r.replyLen > mdcf_pkg::BLK1_PARAMS) payLen = 9'h0ff;
    else payLen = r.replyLen + 9'h002;
  endfunction

  // Reply split only for a successful query longer than block one
  assign multi = respQ.ok && isQueryQ && respQ.replyLen > mdcf_pkg::BLK1_PARAMS;
  assign termIdx = mdcf_pkg::HDR_LEN + payLenQ;
  assign pIdx = chIdx - mdcf_pkg::HDR_LEN;

  // Character of the response block at position chIdx
  always_comb begin
    replyIdx = 9'h000;
    charAt = mdcf_pkg::CH_ZERO;
    if (chIdx == 9'h000) charAt = mdcf_pkg::CH_AT;
    else if (chIdx == 9'h001) charAt = addrHi;
    else if (chIdx == 9'h002) charAt = addrLo;
    else if (chIdx == 9'h003) charAt = mdcf_pkg::CH_STX;
    else if (chIdx == 9'h006) charAt = mdcf_pkg::CH_ZERO + {6'h00, blkTxQ};
    else if (chIdx < 9'h007) charAt = mdcf_pkg::CH_ZERO;
    else if (chIdx == termIdx) begin
      charAt = (multi && blkTxQ == 2'h1) ? mdcf_pkg::CH_ETB
                                         : mdcf_pkg::CH_ETX;
    end else if (chIdx > termIdx) begin
      charAt = lrcQ ^ txDataQ;
    end else if (!respQ.ok) begin
      unique case (pIdx[1:0])
        2'h0: charAt = mdcf_pkg::CH_FAIL;
        2'h1: charAt = respQ.errCode[23:16];
        2'h2: charAt = respQ.errCode[15:8];
        default: charAt = respQ.errCode[7:0];
      endcase
    end else if (!isQueryQ) begin
      charAt = mdcf_pkg::CH_OK;
    end else if (blkTxQ == 2'h2) begin
      replyIdx = pIdx + mdcf_pkg::BLK1_PARAMS;
      charAt = replyChar;
    end else if (pIdx == 9'h000) begin
      charAt = mdcf_pkg::CH_SPACE;
    end else if (pIdx == 9'h001) begin
      charAt = fnCodeQ;
    end else begin
      replyIdx = pIdx - 9'h002;
      charAt = replyChar;
    end
  end

  // Main sequencer: receive, acknowledge, execute, respond
  always_comb begin
    stateD = stateQ;  seqD = seqQ;  idxD = idxQ;  paramCntD = paramCntQ;
    payLenD = payLenQ;  blkExpD = blkExpQ;  blkRxD = blkRxQ;
    blkTxD = blkTxQ;  bodyErrD = bodyErrQ;  isQueryD = isQueryQ;
    endEtxD = endEtxQ;  addrOkD = addrOkQ;  replyAckD = replyAckQ;
    issuedD = issuedQ;  txValidD = txValidQ;  txDataD = txDataQ;
    fnCodeD = fnCodeQ;  respD = respQ;
    lrcClr = 1'b0;  lrcEn = 1'b0;  lrcIn = rxData;  ramWe = 1'b0;
    chIdx = seqQ + 9'h001;
    unique case (stateQ)
      S_IDLE: if (rxValid && rxData == mdcf_pkg::CH_AT) begin
        stateD = S_ADDRH;
        lrcClr = 1'b1;
      end
      S_ADDRH: if (rxValid) begin
        addrOkD = rxData == addrHi && myAddr != 7'h00;
        stateD = S_ADDRL;
      end
      S_ADDRL: if (rxValid) begin
        addrOkD = addrOkQ && rxData == addrLo;
        stateD = S_STX;
      end
      S_STX: if (rxValid) begin
        lrcEn = 1'b1;
        bodyErrD = rxData != mdcf_pkg::CH_STX;
        stateD = S_BLK0;
      end
      S_BLK0, S_BLK1: if (rxValid) begin
        lrcEn = 1'b1;
        if (rxData != mdcf_pkg::CH_ZERO) bodyErrD = 1'b1;
        stateD = (stateQ == S_BLK0) ? S_BLK1 : S_BLK2;
      end
      S_BLK2: if (rxValid) begin
        lrcEn = 1'b1;
        blkRxD = rxData[1:0];
        idxD = 9'h000;
        // A fresh block 001 always restarts the message
        if (rxData == mdcf_pkg::CH_ZERO + 8'h01) paramCntD = 9'h000;
        else if (rxData == mdcf_pkg::CH_ZERO + 8'h02 && blkExpQ == 2'h2)
          paramCntD = mdcf_pkg::BLK1_PARAMS;
        else bodyErrD = 1'b1;
        stateD = S_BODY;
      end
      S_BODY: if (rxValid) begin
        lrcEn = 1'b1;
        idxD = idxQ + 9'h001;
        if (rxData == mdcf_pkg::CH_ETX || rxData == mdcf_pkg::CH_ETB) begin
          endEtxD = rxData == mdcf_pkg::CH_ETX;
          stateD = S_LRC;
          // ETB only closes a full block 001
          if (rxData == mdcf_pkg::CH_ETB && (blkRxQ != 2'h1 ||
              paramCntQ != mdcf_pkg::BLK1_PARAMS)) bodyErrD = 1'b1;
          if (blkRxQ == 2'h1 && idxQ < 9'h002) bodyErrD = 1'b1;
        end else if (idxQ >= mdcf_pkg::MSG_MAX_CHARS) begin
          bodyErrD = 1'b1;
        end else if (blkRxQ == 2'h1 && idxQ == 9'h000) begin
          isQueryD = rxData == mdcf_pkg::CH_QUERY;
          if (rxData != mdcf_pkg::CH_QUERY && rxData != mdcf_pkg::CH_SPACE)
            bodyErrD = 1'b1;
        end else if (blkRxQ == 2'h1 && idxQ == 9'h001) begin
          fnCodeD = rxData;
        end else if (!mdcf_pkg::isHexChar(rxData) ||
                     32'(paramCntQ) >= DEPTH) begin
          bodyErrD = 1'b1;
        end else begin
          ramWe = 1'b1;
          paramCntD = paramCntQ + 9'h001;
        end
      end
      S_LRC: if (rxValid) begin
        if (!addrOkQ) begin
          stateD = S_IDLE;  // Another drop's frame: stay silent
        end else begin
          replyAckD = rxData == lrcQ && !bodyErrQ;
          txValidD = 1'b1;
          txDataD = (rxData == lrcQ && !bodyErrQ) ? mdcf_pkg::CH_ACK
                                                  : mdcf_pkg::CH_NAK;
          seqD = 9'h000;
          stateD = S_REPLY;
        end
      end
      S_REPLY: if (txReady) begin
        if (seqQ == 9'h002) begin
          txValidD = 1'b0;
          if (replyAckQ && endEtxQ) begin
            blkExpD = 2'h1;
            issuedD = 1'b0;
            stateD = S_EXEC;
          end else begin
            if (replyAckQ) blkExpD = 2'h2;
            stateD = S_IDLE;
          end
        end else begin
          seqD = seqQ + 9'h001;
          txDataD = (seqQ == 9'h000) ? addrHi : addrLo;
        end
      end
      S_EXEC: begin
        issuedD = 1'b1;
        if (respValid && issuedQ) begin
          respD = resp;
          blkTxD = 2'h1;
          payLenD = payLen(resp, isQueryQ, 1'b0);
          seqD = 9'h000;
          txValidD = 1'b1;
          txDataD = mdcf_pkg::CH_AT;
          lrcClr = 1'b1;
          stateD = S_RSP;
        end
      end
      S_RSP: if (txReady) begin
        lrcIn = txDataQ;
        lrcEn = seqQ >= 9'h003 && seqQ <= termIdx;
        if (seqQ > termIdx) begin
          txValidD = 1'b0;
          stateD = S_HOSTACK;
        end else begin
          seqD = seqQ + 9'h001;
          txDataD = charAt;
        end
      end
      S_HOSTACK: if (rxValid) begin
        // Trailing address characters fall into S_IDLE or S_RSP and are ignored
        if (rxData == mdcf_pkg::CH_ACK && !(multi && blkTxQ == 2'h1)) begin
          stateD = S_IDLE;
        end else if (rxData == mdcf_pkg::CH_ACK ||
                     rxData == mdcf_pkg::CH_NAK) begin
          if (rxData == mdcf_pkg::CH_ACK) blkTxD = 2'h2;
          payLenD = payLen(respQ, isQueryQ,
                           rxData == mdcf_pkg::CH_ACK || blkTxQ == 2'h2);
          seqD = 9'h000;
          txValidD = 1'b1;
          txDataD = mdcf_pkg::CH_AT;
          lrcClr = 1'b1;
          stateD = S_RSP;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= S_IDLE;  seqQ <= 9'h000;  idxQ <= 9'h000;
      paramCntQ <= 9'h000;  payLenQ <= 9'h000;  blkExpQ <= 2'h1;
      blkRxQ <= 2'h0;  blkTxQ <= 2'h1;  bodyErrQ <= 1'b0;
      isQueryQ <= 1'b0;  endEtxQ <= 1'b0;  addrOkQ <= 1'b0;
      replyAckQ <= 1'b0;  issuedQ <= 1'b0;  txValidQ <= 1'b0;
      txDataQ <= 8'h00;  fnCodeQ <= 8'h00;  respQ <= '0;
    end else begin
      stateQ <= stateD;  seqQ <= seqD;  idxQ <= idxD;
      paramCntQ <= paramCntD;  payLenQ <= payLenD;  blkExpQ <= blkExpD;
      blkRxQ <= blkRxD;  blkTxQ <= blkTxD;  bodyErrQ <= bodyErrD;
      isQueryQ <= isQueryD;  endEtxQ <= endEtxD;  addrOkQ <= addrOkD;
      replyAckQ <= replyAckD;  issuedQ <= issuedD;  txValidQ <= txValidD;
      txDataQ <= txDataD;  fnCodeQ <= fnCodeD;  respQ <= respD;
    end
  end

  // Outputs; cmdValid is a one-cycle pulse on entry to execution
  assign txValid = txValidQ;
  assign txData = txDataQ;
  assign cmdValid = stateQ == S_EXEC && !issuedQ;
  assign cmd = '{isQuery: isQueryQ, fnCode: fnCodeQ, paramLen: paramCntQ};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_ADDR_AFTER_ACK: assert property (
    stateQ == S_REPLY && seqQ == 9'h000 && txReady
    |=> txValid && txData == addrHi
  ) else $error("address high digit does not follow ACK/NAK");
  AST_ADDR_LOW_NEXT: assert property (
    stateQ == S_REPLY && seqQ == 9'h001 && txReady
    |=> txValid && txData == addrLo
  ) else $error("address low digit does not follow high digit");
  AST_CMD_AFTER_ACK: assert property (
    cmdValid |-> $past(stateQ) == S_REPLY && replyAckQ && endEtxQ
  ) else $error("command issued without ACK of final block");
  AST_BAD_LRC_NAK: assert property (
    stateQ == S_LRC && rxValid && addrOkQ && rxData != lrcQ
    |=> txValid && txData == mdcf_pkg::CH_NAK
  ) else $error("bad checksum not answered with NAK");
  AST_RSP_FRAME_START: assert property (
    $rose(stateQ == S_RSP) |-> txValid && txData == mdcf_pkg::CH_AT
  ) else $error("response does not start with frame ID");
  AST_FAIL_CHAR: assert property (
    stateQ == S_RSP && seqQ == 9'h007 && !respQ.ok
    |-> txData == mdcf_pkg::CH_FAIL && payLenQ == 9'h004
  ) else $error("failure reply lacks '!' and code");
  AST_OK_CHAR: assert property (
    stateQ == S_RSP && seqQ == 9'h007 && respQ.ok && !isQueryQ
    |-> txData == mdcf_pkg::CH_OK && payLenQ == 9'h001
  ) else $error("success reply lacks '#'");
  AST_TERMINATOR: assert property (
    stateQ == S_RSP && seqQ == termIdx
    |-> txData == ((multi && blkTxQ == 2'h1) ? mdcf_pkg::CH_ETB
                                             : mdcf_pkg::CH_ETX)
  ) else $error("wrong block terminator");
  AST_BLK2_WAITS: assert property (
    stateQ == S_HOSTACK && !(rxValid && rxData == mdcf_pkg::CH_ACK)
    && !(rxValid && rxData == mdcf_pkg::CH_NAK) |=> !txValid
  ) else $error("block sent before host acknowledged");
  AST_PARAM_BOUND: assert property (
    stateQ == S_LRC && !bodyErrQ && !endEtxQ
    |-> paramCntQ == mdcf_pkg::BLK1_PARAMS
  ) else $error("block one accepted with wrong parameter count");

  COV_CTRL_DONE: cover property (stateQ == S_RSP && respQ.ok && !isQueryQ);
  COV_FAIL: cover property (stateQ == S_RSP && !respQ.ok);
  COV_LONG_QUERY: cover property (stateQ == S_RSP && blkTxQ == 2'h2);
  COV_NAK: cover property (txValid && txData == mdcf_pkg::CH_NAK);

endmodule

// >>> mdcf_pkg.sv
// Shared constants, carrier types and character helpers for the framer.
// Assumes byte-wide ASCII characters and a single system clock.
package mdcf_pkg;

  // Control and framing characters
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_AT    = 8'h40;
  localparam logic [7:0] CH_STX   = 8'h02;
  localparam logic [7:0] CH_ETX   = 8'h03;
  localparam logic [7:0] CH_ETB   = 8'h17;
  localparam logic [7:0] CH_ACK   = 8'h06;
  localparam logic [7:0] CH_NAK   = 8'h15;
  localparam logic [7:0] CH_OK    = 8'h23;
  localparam logic [7:0] CH_FAIL  = 8'h21;
  localparam logic [7:0] CH_ZERO  = 8'h30;

  // Checksum seed
  localparam logic [7:0] LRC_INIT = 8'hff;

  // Block sizing
  localparam logic [8:0] MSG_MAX_CHARS = 9'h0ff;  // 255 per block
  localparam logic [8:0] BLK1_PARAMS   = 9'h0fd;  // 253 params in block 1
  localparam int         PARAM_DEPTH   = 510;
  localparam logic [8:0] FAIL_LEN      = 9'h004;  // '!' plus 3 code chars
  localparam logic [8:0] OK_LEN        = 9'h001;
  localparam logic [8:0] HDR_LEN       = 9'h007;  // @ F F STX d d d

  // Command handed to the unit after the final block is acknowledged
  typedef struct packed {
    logic       isQuery;
    logic [7:0] fnCode;
    logic [8:0] paramLen;
  } mdcf_cmd_t;

  // Outcome handed back by the unit
  typedef struct packed {
    logic        ok;
    logic [23:0] errCode;
    logic [8:0]  replyLen;
  } mdcf_resp_t;

  // Upper-case ASCII hex digit for a nibble
  function automatic logic [7:0] hexToAscii(input logic [3:0] n);
    hexToAscii = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // True for 0-9, A-F, a-f
  function automatic logic isHexChar(input logic [7:0] c);
    isHexChar = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
                (c >= 8'h61 && c <= 8'h66);
  endfunction

endpackage

// >>> mdcf_lrc.sv
// Running XOR checksum for one block, seeded on clear.
// Assumes the caller never asserts clear and enable together.
`timescale 1ns/1ps
module mdcf_lrc (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] din,
  output logic      [7:0] lrc_q
);

  logic [7:0] lrc_d;

  // Seed or fold in one byte
  always_comb begin
    lrc_d = lrc_q;
    if (clr) begin
      lrc_d = mdcf_pkg::LRC_INIT;
    end else if (en) begin
      lrc_d = lrc_q ^ din;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lrc_q <= mdcf_pkg::LRC_INIT;
    end else begin
      lrc_q <= lrc_d;
    end
  end

endmodule

// >>> mdcf_param_ram.sv
// Parameter store: one write port from the receiver, one registered read.
// Assumes indices stay below DEPTH; the writer guards this.
`timescale 1ns/1ps
module mdcf_param_ram #(
  parameter int DEPTH = mdcf_pkg::PARAM_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       wrEn,
  input  wire logic [8:0] wrIdx,
  input  wire logic [7:0] wrData,
  input  wire logic [8:0] rdIdx,
  output logic      [7:0] rdData_q
);

  logic [7:0] mem [DEPTH];
  logic [7:0] rdData_d;

  // Out-of-range reads return zero rather than garbage
  always_comb begin
    rdData_d = 8'h00;
    if (32'(rdIdx) < DEPTH) begin
      rdData_d = mem[rdIdx];
    end
  end

  // Storage has no reset; contents are only read after being written
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= rdData_d;
    end
  end

endmodule

// >>> mdcf_host_model.sv
// Host-side model of the multi-drop link: streams blocks to the framer and
// collects its bytes. Assumes bytes cross as one-cycle strobes on clk_sys.
`timescale 1ns/1ps
module mdcf_host_model (
  input  wire logic       clk_sys,
  output logic            rxValid,
  output logic [7:0]      rxData,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [7:0] txData
);
  logic [7:0] got[$];
  logic       slow;
  int         nTaken;
  int         tick;

  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b0;
    slow    = 1'b0;
    nTaken  = 0;
    tick    = 0;
  end

  // Capture each byte taken by the link
  always @(posedge clk_sys) begin
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txData);
      nTaken++;
    end
  end

  // Slow mode takes one byte in three, to stretch the framer's hold
  always @(negedge clk_sys) begin
    tick    <= tick + 1;
    txReady <= slow ? (tick % 3 == 0) : 1'b1;
  end

  // Back-to-back bytes; afterwards the line shows no stale value
  task automatic sendRaw(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk_sys);
      rxValid = 1'b1;
      rxData  = q[i];
    end
    @(negedge clk_sys);
    rxValid = 1'b0;
    rxData  = ~rxData;
  endtask

  // One block with seeded XOR checksum, optionally corrupted
  task automatic sendBlock(input logic [7:0] a1, input logic [7:0] a2,
                           input logic [7:0] blk, input logic [7:0] msg[$],
                           input logic [7:0] term, input logic badSum);
    logic [7:0] f[$];
    logic [7:0] s;
    f = {8'h40, a1, a2, 8'h02, 8'h30, 8'h30, blk};
    f = {f, msg};
    f.push_back(term);
    s = 8'hff;
    for (int i = 3; i < f.size(); i++) s = s ^ f[i];
    f.push_back(badSum ? ~s : s);
    sendRaw(f);
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the framer: host model on the link, the bench
// plays the pump unit. Assumes a single 50 MHz clock and async reset.
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errTotal++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  typedef logic [7:0] mdcf_bytes_t[$];
  localparam logic [7:0] A1 = 8'h35;
  localparam logic [7:0] A2 = 8'h41;
  logic                 clk_sys;
  logic                 arst_n;
  logic [6:0]           myAddr;
  logic                 rxValid;
  logic [7:0]           rxData;
  logic                 txValid;
  logic                 txReady;
  logic [7:0]           txData;
  logic                 cmdValid;
  mdcf_pkg::mdcf_cmd_t  cmd;
  mdcf_pkg::mdcf_cmd_t  cmdCap;
  logic                 respValid;
  mdcf_pkg::mdcf_resp_t resp;
  logic [8:0]           replyIdx;
  logic [7:0]           replyChar;
  logic [8:0]           paramRdIdx;
  logic [7:0]           paramRdData;
  int                   errTotal;
  int                   nChecks;
  int                   cmdCnt;
  int                   takenAtCmd;
  int                   cyc;

  mdcf_framer mdcf_framer_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .myAddr(myAddr),
    .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
    .txReady(txReady), .txData(txData), .cmdValid(cmdValid), .cmd(cmd),
    .respValid(respValid), .resp(resp), .replyIdx(replyIdx),
    .replyChar(replyChar), .paramRdIdx(paramRdIdx),
    .paramRdData(paramRdData)
  );
  mdcf_host_model mdcf_host_model_inst (
    .clk_sys(clk_sys), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txReady(txReady), .txData(txData)
  );

  // Reply characters cycle A..F so misplaced indices show up
  function automatic logic [7:0] rc(input int i);
    return 8'h41 + 8'(i % 6);
  endfunction
  assign replyChar = rc(int'(replyIdx));

  // Clock, plus hang guard well beyond the longest scenario
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cmdValid === 1'b1) begin
      cmdCnt++;
      cmdCap <= cmd;
      takenAtCmd = mdcf_host_model_inst.nTaken;
    end
    if (cyc == 40000) begin
      errTotal++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("mismatches %0d checks %0d", errTotal, nChecks);
    if (errTotal == 0 && nChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  function automatic mdcf_bytes_t respFrame(input logic [7:0] blk,
                                            input mdcf_bytes_t pay,
                                            input logic [7:0] term);
    mdcf_bytes_t f;
    logic [7:0]  s;
    f = {8'h40, A1, A2, 8'h02, 8'h30, 8'h30, blk};
    f = {f, pay};
    f.push_back(term);
    s = 8'hff;
    for (int i = 3; i < f.size(); i++) s = s ^ f[i];
    f.push_back(s);
    return f;
  endfunction

  // Wait for the expected count, linger to catch extras, then compare
  task automatic expectQ(input mdcf_bytes_t e);
    for (int k = 0; k < 3000 && mdcf_host_model_inst.got.size() < e.size();
         k++) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    `CHK(mdcf_host_model_inst.got.size(), e.size())
    foreach (e[i])
      if (i < mdcf_host_model_inst.got.size())
        `CHK(mdcf_host_model_inst.got[i], e[i])
    mdcf_host_model_inst.got.delete();
  endtask

  task automatic hostAck(input logic [7:0] c);
    mdcf_host_model_inst.sendRaw({c, A1, A2});
  endtask

  // Unit answers from the 3rd cycle after the command pulse
  task automatic giveResp(input logic ok, input logic [23:0] err,
                          input logic [8:0] len, input int c0);
    for (int k = 0; k < 500 && cmdCnt == c0; k++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
    respValid = 1'b1;
    resp      = '{ok: ok, errCode: err, replyLen: len};
    @(negedge clk_sys);
    respValid = 1'b0;
  endtask

  task automatic readParam(input logic [8:0] idx, input logic [7:0] exp);
    @(negedge clk_sys);
    paramRdIdx = idx;
    repeat (2) @(negedge clk_sys);
    `CHK(paramRdData, exp)
  endtask

  task automatic ctrlOk();
    int          t0;
    int          c0;
    mdcf_bytes_t f;
    t0 = mdcf_host_model_inst.nTaken;
    c0 = cmdCnt;
    mdcf_host_model_inst.sendBlock(A1, A2, 8'h31,
      {8'h20, 8'h68, 8'h31, 8'h46, 8'h33, 8'h41}, 8'h03, 1'b0);
    expectQ({8'h06, A1, A2});
    readParam(9'h002, 8'h33);
    mdcf_host_model_inst.slow = 1'b1;
    giveResp(1'b1, 24'h000000, 9'h000, c0);
    `CHK(cmdCap, {1'b0, 8'h68, 9'h004})
    `CHK(takenAtCmd - t0, 3)
    f = respFrame(8'h31, {8'h23}, 8'h03);
    expectQ(f);
    hostAck(8'h15);
    expectQ(f);
    hostAck(8'h06);
    mdcf_host_model_inst.slow = 1'b0;
  endtask

  task automatic queryFail();
    int c0;
    c0 = cmdCnt;
    mdcf_host_model_inst.sendBlock(A1, A2, 8'h31,
      {8'h3f, 8'h4d, 8'h30, 8'h30, 8'h30, 8'h31}, 8'h03, 1'b0);
    expectQ({8'h06, A1, A2});
    giveResp(1'b0, 24'h453037, 9'h000, c0);
    `CHK(cmdCap.isQuery, 1'b1)
    expectQ(respFrame(8'h31, {8'h21, 8'h45, 8'h30, 8'h37}, 8'h03));
    hostAck(8'h06);
  endtask

  task automatic badBlocks();
    mdcf_bytes_t m[3];
    int          c0;
    m[0] = {8'h20, 8'h68, 8'h31};  // Checksum flipped below
    m[1] = {8'h58, 8'h68, 8'h31};  // Unknown type character
    m[2] = {8'h20, 8'h68, 8'h47};  // Not a hex digit
    c0 = cmdCnt;
    for (int i = 0; i < 3; i++) begin
      mdcf_host_model_inst.sendBlock(A1, A2, 8'h31, m[i], 8'h03, i == 0);
      expectQ({8'h15, A1, A2});
    end
    // Block two with no acknowledged block one before it
    mdcf_host_model_inst.sendBlock(A1, A2, 8'h32, {8'h31}, 8'h03, 1'b0);
    expectQ({8'h15, A1, A2});
    // Valid frames to another drop, then to address zero
    mdcf_host_model_inst.sendBlock(8'h31, 8'h31, 8'h31, m[0], 8'h03, 1'b0);
    myAddr = 7'h00;
    mdcf_host_model_inst.sendBlock(8'h30, 8'h30, 8'h31, m[0], 8'h03, 1'b0);
    repeat (40) @(negedge clk_sys);
    myAddr = 7'h5a;
    `CHK(mdcf_host_model_inst.got.size(), 0)
    `CHK(cmdCnt, c0)
  endtask

  task automatic longQuery();
    mdcf_bytes_t m;
    mdcf_bytes_t e;
    int          c0;
    c0 = cmdCnt;
    m = {8'h3f, 8'h63};
    repeat (253) m.push_back(8'h42);
    mdcf_host_model_inst.sendBlock(A1, A2, 8'h31, m, 8'h17, 1'b0);
    expectQ({8'h06, A1, A2});
    m = {8'h43, 8'h44, 8'h45};
    mdcf_host_model_inst.sendBlock(A1, A2, 8'h32, m, 8'h03, 1'b0);
    expectQ({8'h06, A1, A2});
    readParam(9'h0fd, 8'h43);
    giveResp(1'b1, 24'h000000, 9'h100, c0);
    `CHK(cmdCap, {1'b1, 8'h63, 9'h100})
    e = {8'h20, 8'h63};
    for (int i = 0; i < 253; i++) e.push_back(rc(i));
    expectQ(respFrame(8'h31, e, 8'h17));
    hostAck(8'h06);
    e = {rc(253), rc(254), rc(255)};
    expectQ(respFrame(8'h32, e, 8'h03));
    hostAck(8'h06);
  endtask

  // Short query reply fits one block and ends in ETX
  task automatic queryShort();
    mdcf_bytes_t e;
    int          c0;
    c0 = cmdCnt;
    mdcf_host_model_inst.sendBlock(A1, A2, 8'h31, {8'h3f, 8'h64}, 8'h03,
                                   1'b0);
    expectQ({8'h06, A1, A2});
    giveResp(1'b1, 24'h000000, 9'h003, c0);
    `CHK(cmdCap, {1'b1, 8'h64, 9'h000})
    e = {8'h20, 8'h64, rc(0), rc(1), rc(2)};
    expectQ(respFrame(8'h31, e, 8'h03));
    hostAck(8'h06);
  endtask

  // Main sequence
  initial begin
    arst_n     = 1'b0;
    myAddr     = 7'h5a;
    respValid  = 1'b0;
    resp       = '0;
    paramRdIdx = 9'h000;
    errTotal   = 0;
    nChecks    = 0;
    cmdCnt     = 0;
    takenAtCmd = 0;
    cyc        = 0;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    @(negedge clk_sys);
    `CHK(txValid, 1'b0)
    `CHK(cmdValid, 1'b0)
    ctrlOk();
    queryFail();
    badBlocks();
    longQuery();
    queryShort();
    reportAndStop();
  end
endmodule
